// ==== design/doze_gate_regs.vh ====
/*
 * register map, field positions, reset values and ratio codes for the
 * cpu slow-down and peripheral clock gating block.
 * assumes a 32-bit apb slave with word-aligned byte addresses.
 */
`ifndef DOZE_GATE_REGS_VH
`define DOZE_GATE_REGS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CLOCK_DIV 12'h000
`define ADDR_PERIPH_OFF 12'h004
`define ADDR_PERIPH_ACT 12'h008
`define ADDR_STATUS 12'h00C

// ----------------------------------------
// clock divider register fields
// ----------------------------------------
`define SLOW_EN_BIT 11
`define RATIO_HI 14
`define RATIO_LO 12
`define RECOVER_BIT 15
`define RATIO_W 3
`define RATIO_1TO1 3'h0
`define CLOCK_DIV_MASK 32'h0000F800

// ----------------------------------------
// peripheral gating
// ----------------------------------------
`define NUM_PERIPH 8
`define PERIPH_OFF_RST 8'h00
`define PERIPH_PRESENT_DEF 8'hFF
`define PERIPH_ACT_RST 8'h00

// ----------------------------------------
// divider counter
// ----------------------------------------
`define DIV_CNT_W 7
`define DIV_CNT_ZERO 7'h00
`define DIV_CNT_ONE 7'h01
`define WORD_ZERO 32'h00000000

`endif

// ==== design/cpu_doze_and_peripheral_gating.v ====
/*
 * cpu slow-down (doze) and per-peripheral clock gating.
 * cpu clock is a one-cycle enable derived from ref_clk_in, so it stays in
 * step with the peripheral clock. peripheral clocks are enables as well.
 * assumes a 32-bit apb master, synchronous inputs, one clock domain.
 */
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "doze_gate_regs.vh"

module cpu_doze_and_peripheral_gating #(
  parameter [`NUM_PERIPH-1:0] PERIPH_PRESENT = `PERIPH_PRESENT_DEF
) (
  // clock, reset, enable
  input wire ref_clk_in,
  input wire nrst_in,
  input wire clk_en_in,
  // apb slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire pready_out,
  output wire pslverr_out,
  output reg [31:0] prdata_out,
  // interrupt event from the interrupt controller
  input wire irq_event_in,
  // cpu clock enable
  output reg cpu_clk_en_out,
  // peripheral clock enables and register write gates
  input wire [`NUM_PERIPH-1:0] periph_wr_req_in,
  output wire [`NUM_PERIPH-1:0] periph_clk_en_out,
  output wire [`NUM_PERIPH-1:0] periph_wr_en_out,
  output wire [`NUM_PERIPH-1:0] periph_active_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg recover_on_interrupt_r;
  reg slow_en_r;
  reg [`RATIO_W-1:0] ratio_r;
  reg [`NUM_PERIPH-1:0] periph_off_r;
  reg [`NUM_PERIPH-1:0] periph_act_r;
  reg [`DIV_CNT_W-1:0] div_cnt_r;
  reg [`DIV_CNT_W-1:0] div_cnt_nxt;
  reg cpu_tick_nxt;
  reg [31:0] rdata_nxt;
  wire wr_acc;
  wire rd_acc;
  wire [`DIV_CNT_W-1:0] div_max;
  wire [`NUM_PERIPH-1:0] periph_act_nxt;

  // ratio code n divides by 2**n
  function [`DIV_CNT_W-1:0] ratio_to_max;
    input [`RATIO_W-1:0] code;
    begin
      ratio_to_max = (`DIV_CNT_ONE << code) - `DIV_CNT_ONE;
    end
  endfunction

  // single-cycle apb, always ready, never errors
  assign pready_out = 1'b1;
  assign pslverr_out = 1'b0;
  assign wr_acc = psel_in & penable_in & pwrite_in & clk_en_in;
  assign rd_acc = psel_in & ~penable_in & ~pwrite_in & clk_en_in;

  // ----------------------------------------
  // control register writes
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      recover_on_interrupt_r <= 1'b0;
      slow_en_r <= 1'b0;
      ratio_r <= `RATIO_1TO1;
      periph_off_r <= `PERIPH_OFF_RST;
    end else if (clk_en_in) begin
      if (wr_acc && paddr_in == `ADDR_CLOCK_DIV) begin
        recover_on_interrupt_r <= pwdata_in[`RECOVER_BIT];
        ratio_r <= pwdata_in[`RATIO_HI:`RATIO_LO];
        slow_en_r <= pwdata_in[`SLOW_EN_BIT];
      end else if (wr_acc && paddr_in == `ADDR_PERIPH_OFF) begin
        periph_off_r <= pwdata_in[`NUM_PERIPH-1:0];
      end
      // clears slow enable; the interrupt wins over a same-cycle write
      if (recover_on_interrupt_r && irq_event_in) begin
        slow_en_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // cpu divider
  // ----------------------------------------
  assign div_max = ratio_to_max(ratio_r);

  always @* begin
    div_cnt_nxt = div_cnt_r;
    cpu_tick_nxt = 1'b1;
    if (slow_en_r && !(recover_on_interrupt_r && irq_event_in)) begin
      // tick derived from the same clock edge
      if (div_cnt_r >= div_max) begin
        div_cnt_nxt = `DIV_CNT_ZERO;
        cpu_tick_nxt = 1'b1;
      end else begin
        div_cnt_nxt = div_cnt_r + `DIV_CNT_ONE;
        cpu_tick_nxt = 1'b0;
      end
    end else begin
      div_cnt_nxt = `DIV_CNT_ZERO;
    end
  end

  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_cnt_r <= `DIV_CNT_ZERO;
      cpu_clk_en_out <= 1'b1;
    end else if (clk_en_in) begin
      div_cnt_r <= div_cnt_nxt;
      cpu_clk_en_out <= cpu_tick_nxt;
    end
  end

  // ----------------------------------------
  // peripheral gating
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_PERIPH; g = g + 1) begin : gate
      assign periph_act_nxt[g] = PERIPH_PRESENT[g] & ~periph_off_r[g];
      assign periph_clk_en_out[g] = periph_act_r[g] & clk_en_in;
      assign periph_wr_en_out[g] = periph_act_r[g] & periph_wr_req_in[g];
    end
  endgenerate

  // delayed enable
  // one register for all bits; the delay stretches with the cpu tick in doze
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      periph_act_r <= `PERIPH_ACT_RST;
    end else if (clk_en_in && cpu_clk_en_out) begin
      periph_act_r <= periph_act_nxt;
    end
  end

  assign periph_active_out = periph_act_r;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @* begin
    rdata_nxt = `WORD_ZERO;
    if (paddr_in == `ADDR_CLOCK_DIV) begin
      rdata_nxt[`RECOVER_BIT] = recover_on_interrupt_r;
      rdata_nxt[`RATIO_HI:`RATIO_LO] = ratio_r;
      rdata_nxt[`SLOW_EN_BIT] = slow_en_r;
    end else if (paddr_in == `ADDR_PERIPH_OFF) begin
      rdata_nxt[`NUM_PERIPH-1:0] = periph_off_r;
    end else if (paddr_in == `ADDR_PERIPH_ACT) begin
      rdata_nxt[`NUM_PERIPH-1:0] = periph_act_r;
    end else if (paddr_in == `ADDR_STATUS) begin
      rdata_nxt[`DIV_CNT_W-1:0] = div_cnt_r;
    end
  end

  // data registered in setup so it is stable during the access phase
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= `WORD_ZERO;
    end else if (rd_acc) begin
      prdata_out <= rdata_nxt;
    end
  end

endmodule

// ==== test/doze_gate_checker.sv ====
/* checker for the doze and gating block, bound to its top module.
   assumes one clock; cycles with clk_en_in low are frozen and not judged. */
`timescale 1ns/100ps
`include "doze_gate_regs.vh"
module doze_gate_checker #(parameter [7:0] PERIPH_PRESENT = 8'hFF) (
  input wire ref_clk_in, nrst_in, clk_en_in, psel_in, penable_in, pwrite_in, cpu_clk_en_out,
  input wire [11:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire [7:0] periph_wr_req_in, periph_clk_en_out, periph_wr_en_out, periph_active_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in || !clk_en_in);
  property p_gate; periph_clk_en_out == periph_active_out; endproperty
  a_gate: assert property (p_gate) else $error("peripheral clock gate wrong");
  property p_wr; periph_wr_en_out == (periph_active_out & periph_wr_req_in); endproperty
  a_wr: assert property (p_wr) else $error("peripheral write gate wrong");
  property p_present; (periph_active_out & ~PERIPH_PRESENT) == 8'h00; endproperty
  a_present: assert property (p_present) else $error("absent peripheral active");
  property p_rst; $rose(nrst_in) |=> periph_active_out == PERIPH_PRESENT; endproperty
  a_rst: assert property (p_rst) else $error("peripherals not on after reset");
  property p_full; $rose(nrst_in) |-> cpu_clk_en_out [*4]; endproperty
  a_full: assert property (p_full) else $error("cpu not full speed after reset");
  property p_tick; $changed(periph_active_out) |-> $past(cpu_clk_en_out); endproperty
  a_tick: assert property (p_tick) else $error("gating off instruction tick");
  property p_gap; $fell(cpu_clk_en_out) |-> ##[1:127] cpu_clk_en_out; endproperty
  a_gap: assert property (p_gap) else $error("cpu tick gap too long");
  property p_rd; psel_in && !penable_in && !pwrite_in && paddr_in == `ADDR_CLOCK_DIV
    |=> (prdata_out & ~`CLOCK_DIV_MASK) == 32'h00000000; endproperty
  a_rd: assert property (p_rd) else $error("divider unused bits set");
endmodule
bind cpu_doze_and_peripheral_gating doze_gate_checker #(.PERIPH_PRESENT(PERIPH_PRESENT))
  i_doze_gate_checker (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .cpu_clk_en_out(cpu_clk_en_out), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .periph_wr_req_in(periph_wr_req_in), .periph_clk_en_out(periph_clk_en_out),
  .periph_wr_en_out(periph_wr_en_out), .periph_active_out(periph_active_out));

// ==== test/cpu_doze_and_peripheral_gating_tb.sv ====
/* directed bench for the doze and gating block over apb.
   assumes the design header and checker are compiled before it. */
`timescale 1ns/100ps
`include "doze_gate_regs.vh"
module cpu_doze_and_peripheral_gating_tb;
  logic ref_clk_in = 0, nrst_in = 0, clk_en_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, irq_event_in = 0, pready_out, pslverr_out, cpu_clk_en_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
  logic [7:0] periph_wr_req_in = 8'h3C, periph_clk_en_out, periph_wr_en_out, periph_active_out;
  int n_errors = 0, checks = 0, cyc = 0;
  cpu_doze_and_peripheral_gating i_cpu_doze_and_peripheral_gating (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
    .irq_event_in(irq_event_in), .cpu_clk_en_out(cpu_clk_en_out),
    .periph_wr_req_in(periph_wr_req_in), .periph_clk_en_out(periph_clk_en_out),
    .periph_wr_en_out(periph_wr_en_out), .periph_active_out(periph_active_out)
  );
  always #2 ref_clk_in = ~ref_clk_in;
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // waits for pready, never assumes its latency
  task automatic apb(bit w, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic irq;
    irq_event_in <= 1'b1;
    @(posedge ref_clk_in);
    irq_event_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up;
    end
  end
  task automatic t_reset;
    apb(0, `ADDR_CLOCK_DIV, 0);
    cmp("divider", 32'h00000000, rd);
    apb(0, `ADDR_PERIPH_ACT, 0);
    cmp("active", 32'h000000FF, rd);
    apb(0, 12'h010, 0);
    cmp("unmapped", 32'h00000000, rd);
    cmp("slave error", 0, pslverr_out);
  endtask
  // first tick after a ratio change may be partial, so time tick to tick
  task automatic t_doze;
    int n;
    for (int r = 0; r < 8; r++) begin
      apb(1, `ADDR_CLOCK_DIV, 32'h00000800 | (r << 12));
      do @(posedge ref_clk_in); while (cpu_clk_en_out !== 1'b1);
      n = 0;
      do begin
        @(posedge ref_clk_in);
        n++;
      end while (cpu_clk_en_out !== 1'b1);
      cmp("doze period", 1 << r, n);
      cmp("periph clocks", 8'hFF, periph_clk_en_out);
    end
  endtask
  task automatic t_roi;
    apb(1, `ADDR_CLOCK_DIV, 32'h00003800);
    irq;
    apb(0, `ADDR_CLOCK_DIV, 0);
    cmp("no recovery", 32'h00003800, rd);
    apb(1, `ADDR_CLOCK_DIV, 32'h0000B800);
    irq;
    repeat (4) begin
      @(negedge ref_clk_in);
      cmp("cpu tick", 1, cpu_clk_en_out);
    end
    apb(0, `ADDR_CLOCK_DIV, 0);
    cmp("doze cleared", 32'h0000B000, rd);
  endtask
  task automatic t_gate;
    apb(1, `ADDR_PERIPH_OFF, 32'h00000005);
    @(negedge ref_clk_in);
    cmp("still active", 8'hFF, periph_active_out);
    @(negedge ref_clk_in);
    cmp("active", 8'hFA, periph_active_out);
    cmp("clocks", 8'hFA, periph_clk_en_out);
    cmp("writes", 8'h38, periph_wr_en_out);
    apb(1, `ADDR_PERIPH_OFF, 0);
    @(negedge ref_clk_in);
    cmp("still off", 8'hFA, periph_active_out);
    @(negedge ref_clk_in);
    cmp("active", 8'hFF, periph_active_out);
    @(posedge ref_clk_in) clk_en_in <= 1'b0;
    @(negedge ref_clk_in);
    cmp("frozen", 8'h00, periph_clk_en_out);
    @(posedge ref_clk_in) clk_en_in <= 1'b1;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    t_reset;
    t_doze;
    t_roi;
    t_gate;
    wrap_up;
  end
endmodule
